// file: clock_config.sv
// clock configuration register 0 with decoded divider and mux controls
// assumes strobes are single-cycle and synchronous to clock_in; event inputs are async pins
`default_nettype none
// Summary of operation
// [R1] whole register resets to zero: internal 8 MHz source, no ahb or apb division, no clock out
// [R2] clock out select 00xx none, 0100 system, 0101 internal_rc_8mhz, 0110 crystal, 0111 pll/2
// [R3] clock out 1000 pll1, 1001 pll2/2, 1010 crystal, 1011 pll2, 1100 48m, 1101 48m/8
// [R4] usb prescaler from bit31 and 23:22 divides pll by 1.5,1,2.5,2,3,3.5,4
// [R5] usb prescaler bits cannot be cleared while usb clock is enabled
// [R6] software keeps the usb clock at exactly 48 MHz
// [R7] pll multiplier codes 0 to 12 give code plus two, 13 gives 6.5
// [R8] codes 14,15 give 16; 16 to 30 give code plus one; 31 gives 31
// [R9] software keeps the pll output at or below 120 MHz
// [R10] bit 17 always equals predivider bit 0 of the second register
// [R11] with predivider bits 3:1 zero, bit 17 alone selects divide by two
// [R12] bit 16 picks internal_rc_8mhz/2 or crystal/48m chosen by the preselect bit
// [R13] adc prescaler codes 0000-0111 divide apb2 by 2,4,6,8,2,12,16,16
// [R14] adc msb set: 1x00 ahb/3, 1x01 and 1x11 ahb/5, 1x10 undefined
// [R15] apb2 divider 0xx none, 100-111 divide by 2,4,8,16
// [R16] apb1 divider uses the apb2 encoding
// [R17] software keeps apb1 at or below 60 MHz
// [R18] ahb divider 0xxx none, 1000-1111 divide by 2,4,8,16,64,128,256,512
// [R19] bits 3:2 report the active source: 00 internal_rc_8mhz, 01 crystal, 10 pll
// [R20] bits 1:0 request a source; status follows after switch latency
// [R21] deep-sleep or standby exit and crystal failure force the internal_rc_8mhz source
// [R22] software writes reserved bit 30 as zero
// [R23] enabled monitor seeing a stuck crystal switches to internal_rc_8mhz and forces it on
// [R24] stuck crystal sets a flag cleared by writing one to its clear bit
// [R25] reserved source request 11 is ignored; current source is kept
module clock_config
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   output logic [31:0] rdata_out,
   input wire logic usb_clock_enabled_in,
   input wire logic [3:0] pll_predivider_in,
   input wire logic pll_preselect_in,
   input wire logic adc_prescaler_msb_in,
   input wire logic lowpower_exit_in,
   input wire logic crystal_stuck_in,
   output logic predivider_lsb_write_out,
   output logic predivider_lsb_value_out,
   output logic [1:0] sysclk_select_out,
   output logic internal_rc_8mhz_force_on_out,
   output clock_config_pkg::clock_ctrl_s ctrl_out
);
   // =====================================================
   // input synchronisers
   // =====================================================
   logic [1:0] exit_sync_ff;
   logic [1:0] stuck_sync_ff;
   logic exit_seen_ff;
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         exit_sync_ff <= 2'h0;
         stuck_sync_ff <= 2'h0;
         exit_seen_ff <= 1'b0;
      end
      else
      begin
         exit_sync_ff <= {exit_sync_ff[0], lowpower_exit_in};
         stuck_sync_ff <= {stuck_sync_ff[0], crystal_stuck_in};
         exit_seen_ff <= exit_sync_ff[1];
      end
   end
   logic exit_pulse;
   logic stuck_level;
   assign exit_pulse = exit_sync_ff[1] & ~exit_seen_ff;
   assign stuck_level = stuck_sync_ff[1];

   // =====================================================
   // register storage
   // =====================================================
   logic cfg0_wr;
   logic mon_wr;
   assign cfg0_wr = write_in && (addr_in == clock_config_pkg::CFG0_OFFSET);
   assign mon_wr = write_in && (addr_in == clock_config_pkg::MONITOR_OFFSET);

   logic [31:0] cfg_ff;
   logic monitor_en_ff;
   logic stuck_flag_ff;
   logic crystal_fail;
   logic [1:0] status_ff;
   logic [1:0] pending_ff;
   logic [3:0] switch_cnt_ff;
   logic force_irc;

   // crystal feeds the system clock directly or via the pll source
   assign crystal_fail = monitor_en_ff && stuck_level &&
      ((status_ff == clock_config_pkg::SRC_CRYSTAL) ||
       ((status_ff == clock_config_pkg::SRC_PLL) && cfg_ff[clock_config_pkg::PLL_SOURCE_SELECT_BIT]
        && !pll_preselect_in)); // [R21]
   assign force_irc = exit_pulse || crystal_fail; // [R21] [R23]

   logic [31:0] nxt_cfg;
   logic [2:0] old_usb;
   logic [2:0] new_usb;
   always_comb
   begin
      nxt_cfg = cfg_ff;
      old_usb = {cfg_ff[clock_config_pkg::USB_MSB_BIT],
                 cfg_ff[clock_config_pkg::USB_LO+1:clock_config_pkg::USB_LO]};
      new_usb = {wdata_in[clock_config_pkg::USB_MSB_BIT],
                 wdata_in[clock_config_pkg::USB_LO+1:clock_config_pkg::USB_LO]};
      if (cfg0_wr)
      begin
         nxt_cfg = wdata_in;
         nxt_cfg[clock_config_pkg::RESERVED_BIT] = 1'b0; // [R22]
         nxt_cfg[clock_config_pkg::STATUS_LO+1:clock_config_pkg::STATUS_LO] = 2'h0;
         // a write that would clear any usb bit keeps the old field while usb runs
         if (usb_clock_enabled_in && ((old_usb & ~new_usb) != 3'h0))
         begin
            nxt_cfg[clock_config_pkg::USB_MSB_BIT] = old_usb[2]; // [R5]
            nxt_cfg[clock_config_pkg::USB_LO+1:clock_config_pkg::USB_LO] = old_usb[1:0]; // [R5]
         end
         if (wdata_in[clock_config_pkg::REQ_LO+1:clock_config_pkg::REQ_LO] ==
             clock_config_pkg::SRC_RESERVED)
            nxt_cfg[clock_config_pkg::REQ_LO+1:clock_config_pkg::REQ_LO] =
               cfg_ff[clock_config_pkg::REQ_LO+1:clock_config_pkg::REQ_LO]; // [R25]
      end
      // the mirror always follows the second register
      nxt_cfg[clock_config_pkg::PREDIV_LSB_BIT] = pll_predivider_in[0]; // [R10]
      if (force_irc)
         nxt_cfg[clock_config_pkg::REQ_LO+1:clock_config_pkg::REQ_LO] =
            clock_config_pkg::SRC_INTERNAL_RC_8MHZ; // [R21]
   end

   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         cfg_ff <= clock_config_pkg::CFG0_RESET; // [R1]
      else
         cfg_ff <= nxt_cfg;
   end

   // writes to bit 17 are passed to the second register, which owns the bit
   assign predivider_lsb_write_out = cfg0_wr; // [R10]
   assign predivider_lsb_value_out = wdata_in[clock_config_pkg::PREDIV_LSB_BIT];

   // =====================================================
   // crystal monitor control and flag
   // =====================================================
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         monitor_en_ff <= 1'b0;
      else if (mon_wr)
         monitor_en_ff <= wdata_in[clock_config_pkg::MON_ENABLE_BIT];
   end

   // set wins over a same-cycle clear
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         stuck_flag_ff <= 1'b0;
      else if (monitor_en_ff && stuck_level)
         stuck_flag_ff <= 1'b1; // [R24]
      else if (mon_wr && wdata_in[clock_config_pkg::MON_CLEAR_BIT])
         stuck_flag_ff <= 1'b0; // [R24]
   end
   assign internal_rc_8mhz_force_on_out = monitor_en_ff; // [R23]

   // =====================================================
   // source switch with latency
   // =====================================================
   // the mux itself lives outside; the counter models its settling time
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         status_ff <= clock_config_pkg::SRC_INTERNAL_RC_8MHZ; // [R1]
         pending_ff <= clock_config_pkg::SRC_INTERNAL_RC_8MHZ;
         switch_cnt_ff <= 4'h0;
      end
      else if (force_irc)
      begin
         status_ff <= clock_config_pkg::SRC_INTERNAL_RC_8MHZ; // [R21] [R23]
         pending_ff <= clock_config_pkg::SRC_INTERNAL_RC_8MHZ;
         switch_cnt_ff <= 4'h0;
      end
      else if (cfg_ff[1:0] != pending_ff)
      begin
         pending_ff <= cfg_ff[1:0]; // [R20]
         switch_cnt_ff <= clock_config_pkg::SWITCH_LATENCY;
      end
      else if (switch_cnt_ff != 4'h0)
      begin
         switch_cnt_ff <= switch_cnt_ff - 4'h1;
         if (switch_cnt_ff == 4'h1)
            status_ff <= pending_ff; // [R19] [R20]
      end
   end
   assign sysclk_select_out = status_ff;

   // =====================================================
   // field decoders
   // =====================================================
   function automatic logic [4:0] apb_div(input logic [2:0] code);
      logic [4:0] r;
      r = 5'h01;
      if (code[2])
         r = 5'(5'h02 << code[1:0]);
      return r;
   endfunction

   function automatic logic [5:0] pll_mult_x2(input logic [4:0] code);
      logic [5:0] r;
      if (code <= 5'h0c)
         r = 6'((code + 5'h02) << 1); // [R7]
      else if (code == 5'h0d)
         r = 6'h0d; // [R7]
      else if (code <= 5'h0f)
         r = 6'h20; // [R8]
      else if (code == 5'h1f)
         r = 6'h3e; // [R8]
      else
         r = 6'({1'b0, code} + 6'h01) << 1; // [R8]
      return r;
   endfunction

   logic [4:0] mult_code;
   logic [2:0] usb_code;
   logic [3:0] adc_code;
   logic [3:0] ahb_code;
   logic [3:0] ckout_code;
   assign mult_code = {cfg_ff[clock_config_pkg::PLL_MULTIPLIER_MSB_BIT],
                       cfg_ff[clock_config_pkg::PLL_MULTIPLIER_LO+3:clock_config_pkg::PLL_MULTIPLIER_LO]};
   assign usb_code = {cfg_ff[clock_config_pkg::USB_MSB_BIT],
                      cfg_ff[clock_config_pkg::USB_LO+1:clock_config_pkg::USB_LO]};
   assign adc_code = {adc_prescaler_msb_in, cfg_ff[clock_config_pkg::ADC_MID_BIT],
                      cfg_ff[clock_config_pkg::ADC_LO+1:clock_config_pkg::ADC_LO]};
   assign ahb_code = cfg_ff[clock_config_pkg::AHB_LO+3:clock_config_pkg::AHB_LO];
   assign ckout_code = cfg_ff[clock_config_pkg::CKOUT_LO+3:clock_config_pkg::CKOUT_LO];

   clock_config_pkg::clock_ctrl_s nxt_ctrl;
   always_comb
   begin
      nxt_ctrl = '0;
      nxt_ctrl.pll_mult_x2 = pll_mult_x2(mult_code);
      unique case (usb_code) // [R4]
         3'h0: nxt_ctrl.usb_div_x2 = 4'h3;
         3'h1: nxt_ctrl.usb_div_x2 = 4'h2;
         3'h2: nxt_ctrl.usb_div_x2 = 4'h5;
         3'h3: nxt_ctrl.usb_div_x2 = 4'h4;
         3'h4: nxt_ctrl.usb_div_x2 = 4'h6;
         3'h5: nxt_ctrl.usb_div_x2 = 4'h7;
         default: nxt_ctrl.usb_div_x2 = 4'h8;
      endcase
      nxt_ctrl.ahb_div = 10'h001; // [R18]
      if (ahb_code[3])
         nxt_ctrl.ahb_div = ahb_code[2] ? 10'(10'h040 << ahb_code[1:0])
                                        : 10'(10'h002 << ahb_code[1:0]); // [R18]
      nxt_ctrl.apb2_div = apb_div(cfg_ff[clock_config_pkg::APB2_LO+2:clock_config_pkg::APB2_LO]); // [R15]
      nxt_ctrl.apb1_div = apb_div(cfg_ff[clock_config_pkg::APB1_LO+2:clock_config_pkg::APB1_LO]); // [R16]
      nxt_ctrl.adc_from_ahb = adc_code[3]; // [R14]
      if (adc_code[3])
         nxt_ctrl.adc_div = (adc_code[1:0] == 2'h0) ? 5'h03 : 5'h05; // [R14] 1x10 taken as /5
      else
         unique case (adc_code[2:0]) // [R13]
            3'h0: nxt_ctrl.adc_div = 5'h02;
            3'h1: nxt_ctrl.adc_div = 5'h04;
            3'h2: nxt_ctrl.adc_div = 5'h06;
            3'h3: nxt_ctrl.adc_div = 5'h08;
            3'h4: nxt_ctrl.adc_div = 5'h02;
            3'h5: nxt_ctrl.adc_div = 5'h0c;
            default: nxt_ctrl.adc_div = 5'h10;
         endcase
      nxt_ctrl.pll_from_ext = cfg_ff[clock_config_pkg::PLL_SOURCE_SELECT_BIT]; // [R12]
      nxt_ctrl.pll_use_48m = cfg_ff[clock_config_pkg::PLL_SOURCE_SELECT_BIT] & pll_preselect_in; // [R12]
      nxt_ctrl.prediv_by2 = (pll_predivider_in[3:1] == 3'h0) &&
                            cfg_ff[clock_config_pkg::PREDIV_LSB_BIT]; // [R11]
      // codes 1110 and 1111 have no source and drive nothing
      if ((ckout_code[3:2] == 2'h0) || (ckout_code > 4'hd))
         nxt_ctrl.ckout = clock_config_pkg::CKOUT_NONE; // [R2]
      else
         nxt_ctrl.ckout = clock_config_pkg::ckout_sel_e'(ckout_code); // [R2] [R3]
   end

   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         ctrl_out <= '0;
      else
         ctrl_out <= nxt_ctrl;
   end

   // =====================================================
   // read port
   // =====================================================
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
         rdata_out <= 32'h00000000;
      else if (read_in && (addr_in == clock_config_pkg::CFG0_OFFSET))
         rdata_out <= {cfg_ff[31:4], status_ff, cfg_ff[1:0]}; // [R19]
      else if (read_in && (addr_in == clock_config_pkg::MONITOR_OFFSET))
         rdata_out <= {30'h0, stuck_flag_ff, monitor_en_ff};
      else
         rdata_out <= 32'h00000000;
   end
endmodule
`default_nettype wire

// file: clock_config_pkg.sv
// package of the clock configuration block: register offset, field positions, encodings
// assumes a single 200 MHz system clock domain and the plain register port
`default_nettype none
package clock_config_pkg;
   localparam logic [7:0] CFG0_OFFSET = 8'h04;
   localparam logic [7:0] CFG1_MIRROR_OFFSET = 8'h2c;
   localparam logic [7:0] MONITOR_OFFSET = 8'h08;
   localparam logic [31:0] CFG0_RESET = 32'h00000000;
   localparam int USB_MSB_BIT = 31;
   localparam int RESERVED_BIT = 30;
   localparam int PLL_MULTIPLIER_MSB_BIT = 29;
   localparam int ADC_MID_BIT = 28;
   localparam int CKOUT_LO = 24;
   localparam int USB_LO = 22;
   localparam int PLL_MULTIPLIER_LO = 18;
   localparam int PREDIV_LSB_BIT = 17;
   localparam int PLL_SOURCE_SELECT_BIT = 16;
   localparam int ADC_LO = 14;
   localparam int APB2_LO = 11;
   localparam int APB1_LO = 8;
   localparam int AHB_LO = 4;
   localparam int STATUS_LO = 2;
   localparam int REQ_LO = 0;
   // monitor register fields (block-local)
   localparam int MON_ENABLE_BIT = 0;
   localparam int MON_FLAG_BIT = 1;
   localparam int MON_CLEAR_BIT = 2;
   // cycles from loading the pending request to the status update, one cycle after the write
   localparam logic [3:0] SWITCH_LATENCY = 4'h8;

   typedef enum logic [1:0]
   {
      SRC_INTERNAL_RC_8MHZ = 2'b00,
      SRC_CRYSTAL = 2'b01,
      SRC_PLL = 2'b10,
      SRC_RESERVED = 2'b11
   } sysclk_src_e;

   typedef enum logic [3:0]
   {
      CKOUT_NONE = 4'h0,
      CKOUT_SYSTEM = 4'h4,
      CKOUT_INTERNAL_RC_8MHZ = 4'h5,
      CKOUT_CRYSTAL = 4'h6,
      CKOUT_PLL_HALF = 4'h7,
      CKOUT_PLL1 = 4'h8,
      CKOUT_PLL2_HALF = 4'h9,
      CKOUT_HIGHSPEED_CRYSTAL_OSC = 4'ha,
      CKOUT_PLL2 = 4'hb,
      CKOUT_INTERNAL_RC_48MHZ = 4'hc,
      CKOUT_INTERNAL_RC_48MHZ_DIV8 = 4'hd
   } ckout_sel_e;

   // pll and usb ratios in half steps (value x2) so 1.5, 2.5, 3.5 and 6.5 stay integer; the other dividers are plain
   typedef struct packed
   {
      logic [5:0] pll_mult_x2;
      logic [3:0] usb_div_x2;
      logic [9:0] ahb_div;
      logic [4:0] apb1_div;
      logic [4:0] apb2_div;
      logic [4:0] adc_div;
      logic adc_from_ahb;
      logic pll_from_ext;
      logic pll_use_48m;
      logic prediv_by2;
      ckout_sel_e ckout;
   } clock_ctrl_s;
endpackage
`default_nettype wire

// file: clock_config_properties.sv
// checker of the clock configuration block, watching the top module ports only
// assumes one clock domain; bound to the design from the testbench top file
`default_nettype none
module clock_config_properties
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   input wire logic [31:0] rdata_out,
   input wire logic lowpower_exit_in,
   input wire logic crystal_stuck_in,
   input wire logic predivider_lsb_write_out,
   input wire logic predivider_lsb_value_out,
   input wire logic [1:0] sysclk_select_out,
   input wire logic internal_rc_8mhz_force_on_out,
   input wire clock_config_pkg::clock_ctrl_s ctrl_out
);
   // ==========================================
   // helpers
   logic cfg0_wr;
   assign cfg0_wr = write_in && addr_in == clock_config_pkg::CFG0_OFFSET;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   // ==========================================
   // properties
   chk_lsb_write_pulse: assert property (predivider_lsb_write_out == cfg0_wr)
      else $error("predivider copy write pulse wrong");
   chk_lsb_value: assert property (cfg0_wr |-> predivider_lsb_value_out == wdata_in[17])
      else $error("predivider copy value wrong");
   chk_status_legal: assert property (sysclk_select_out != 2'b11)
      else $error("reserved source reported");
   chk_read_status: assert property ($past(read_in && addr_in == 8'h04) |->
      rdata_out[3:2] == $past(sysclk_select_out) && !rdata_out[30])
      else $error("read status or reserved bit wrong");
   // a switch must not show early: status stays put until the latency ends
   chk_switch_hold: assert property (cfg0_wr && wdata_in[1:0] != 2'b11 &&
      wdata_in[1:0] != sysclk_select_out |=> $stable(sysclk_select_out)[*8])
      else $error("status changed early");
   chk_switch_done: assert property (cfg0_wr && wdata_in[1:0] != 2'b11 &&
      wdata_in[1:0] != sysclk_select_out |-> ##10 sysclk_select_out == $past(wdata_in[1:0], 10))
      else $error("switch not completed on time");
   chk_reserved_req: assert property (cfg0_wr && wdata_in[1:0] == 2'b11 |=>
      $stable(sysclk_select_out)[*8])
      else $error("reserved request changed source");
   chk_apb1_decode: assert property (cfg0_wr ##1 !cfg0_wr |=> ctrl_out.apb1_div ==
      ($past(wdata_in[10], 2) ? 5'(2 << $past(wdata_in[9:8], 2)) : 5'h01))
      else $error("apb1 divider decode wrong");
   chk_wake_force: assert property ($rose(lowpower_exit_in) |->
      ##[1:6] sysclk_select_out == 2'b00)
      else $error("wake did not force internal_rc_8mhz");
   chk_stuck_force: assert property ($rose(crystal_stuck_in) && internal_rc_8mhz_force_on_out &&
      sysclk_select_out == 2'b01 |-> ##[1:6] sysclk_select_out == 2'b00)
      else $error("stuck crystal did not force internal_rc_8mhz");
   cover property (cfg0_wr ##10 $changed(sysclk_select_out));
   cover property ($rose(crystal_stuck_in) && internal_rc_8mhz_force_on_out);
   cover property (read_in ##1 rdata_out != 32'h0);
endmodule
`default_nettype wire

// file: clock_config_test.sv
// testbench of the clock configuration block: reset, decodes, usb lock, switch, forcing
// assumes the package and the checker are compiled first; one 200 MHz clock
`default_nettype none
module clock_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // signals and helpers
   logic clock_in, arst_n_in, write_in, read_in, usb_clock_enabled_in, pll_preselect_in;
   logic adc_prescaler_msb_in, lowpower_exit_in, crystal_stuck_in, internal_rc_8mhz_force_on_out;
   logic predivider_lsb_write_out, predivider_lsb_value_out;
   logic [7:0] addr_in;
   logic [31:0] wdata_in, rdata_out, got;
   logic [3:0] pll_predivider_in;
   logic [1:0] sysclk_select_out;
   clock_config_pkg::clock_ctrl_s ctrl_out, e;
   int bad_count, samples_checked;
   localparam logic [3:0] USB_X2 [8] = '{4'h3, 4'h2, 4'h5, 4'h4, 4'h6, 4'h7, 4'h8, 4'h8};
   localparam logic [4:0] ADC_DIV [16] = '{5'h02, 5'h04, 5'h06, 5'h08, 5'h02, 5'h0c,
      5'h10, 5'h10, 5'h03, 5'h05, 5'h05, 5'h05, 5'h03, 5'h05, 5'h05, 5'h05};
   clock_config dut (.clock_in, .arst_n_in, .addr_in, .wdata_in, .write_in, .read_in,
      .rdata_out, .usb_clock_enabled_in, .pll_predivider_in, .pll_preselect_in,
      .adc_prescaler_msb_in, .lowpower_exit_in, .crystal_stuck_in, .predivider_lsb_write_out,
      .predivider_lsb_value_out, .sysclk_select_out, .internal_rc_8mhz_force_on_out, .ctrl_out);
   initial
   begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   task automatic cyc(int n);
      repeat (n) @(posedge clock_in);
   endtask
   task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clock_in);
      write_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge clock_in);
      write_in <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clock_in);
      read_in <= 1'b1;
      addr_in <= a;
      @(posedge clock_in);
      read_in <= 1'b0;
      #1 got = rdata_out;
   endtask
   function automatic logic [4:0] apbd(logic [2:0] c);
      return c[2] ? 5'(2 << c[1:0]) : 5'h01;
   endfunction
   // ==========================================
   // scenarios
   task automatic t_reset;
      e = '0;
      e.pll_mult_x2 = 6'h04;
      e.usb_div_x2 = 4'h3;
      e.ahb_div = 10'h001;
      e.apb1_div = 5'h01;
      e.apb2_div = 5'h01;
      e.adc_div = 5'h02;
      check("reset ctrl", 64'(ctrl_out), 64'(e));
      rd(8'h04);
      check("reset cfg0", got, 32'h0);
   endtask
   task automatic t_unmapped;
      wr(8'h10, 32'hffffffff);
      rd(8'h10);
      check("unmapped", got, 32'h0);
      rd(8'h04);
      check("cfg0 kept", got, 32'h0);
   endtask
   // one word per code sweeps every field at once: 32 codes reach all encodings
   task automatic t_decode;
      logic [4:0] m;
      logic [3:0] k;
      logic [2:0] u, p, q;
      logic [31:0] w;
      for (int i = 0; i < 32; i++)
      begin
         m = 5'(i);
         k = 4'(i);
         u = 3'(i);
         p = 3'(i + 3);
         q = 3'(i + 5);
         @(posedge clock_in);
         adc_prescaler_msb_in <= k[3];
         pll_predivider_in <= {3'h0, k[1]};
         pll_preselect_in <= k[2];
         w = {u[2], 1'b1, m[4], u[2], k, u[1:0], m[3:0], ~k[1], k[0], u[1:0], q, p, k, 4'hc};
         e.pll_mult_x2 = m < 13 ? 6'((m + 2) * 2) : m == 13 ? 6'h0d : m < 16 ? 6'h20 :
            m == 31 ? 6'h3e : 6'((m + 1) * 2);
         e.usb_div_x2 = USB_X2[u];
         e.ahb_div = k[3] ? 10'(2 << (int'(k[2:0]) + int'(k[2:0] > 3))) : 10'h001;
         e.apb1_div = apbd(p);
         e.apb2_div = apbd(q);
         e.adc_div = ADC_DIV[{k[3], u}];
         e.adc_from_ahb = k[3];
         e.pll_from_ext = k[0];
         // only ratios are decoded here, so no generated clock can break a limit
         e.pll_use_48m = k[0] & k[2];
         e.prediv_by2 = k[1];
         e.ckout = clock_config_pkg::ckout_sel_e'((k < 4 || k > 13) ? 4'h0 : k);
         wr(8'h04, w);
         cyc(2);
         #1 check("ctrl", 64'(ctrl_out), 64'(e));
         rd(8'h04);
         check("cfg0", got, {w[31], 1'b0, w[29:18], k[1], w[16:4], 4'h0});
      end
   endtask
   task automatic t_usb;
      pll_predivider_in <= 4'h0;
      wr(8'h04, 32'h80c00000);
      @(posedge clock_in);
      usb_clock_enabled_in <= 1'b1;
      wr(8'h04, 32'h00400000);
      rd(8'h04);
      check("usb locked", got, 32'h80c00000);
      @(posedge clock_in);
      usb_clock_enabled_in <= 1'b0;
      wr(8'h04, 32'h0);
      rd(8'h04);
      check("usb cleared", got, 32'h0);
   endtask
   task automatic t_switch;
      wr(8'h04, 32'h2);
      cyc(8);
      #1 check("status early", sysclk_select_out, 2'b00);
      cyc(1);
      #1 check("status done", sysclk_select_out, 2'b10);
      rd(8'h04);
      check("status read", got, 32'h0a);
      wr(8'h04, 32'h3);
      cyc(12);
      rd(8'h04);
      check("reserved req", got, 32'h0a);
      wr(8'h04, 32'h1);
      cyc(10);
      #1 check("crystal", sysclk_select_out, 2'b01);
   endtask
   task automatic t_force;
      wr(8'h08, 32'h1);
      cyc(2);
      #1 check("force on", internal_rc_8mhz_force_on_out, 1'b1);
      @(posedge clock_in);
      crystal_stuck_in <= 1'b1;
      cyc(6);
      #1 check("stuck force", sysclk_select_out, 2'b00);
      rd(8'h04);
      check("stuck req", got[3:0], 4'h0);
      rd(8'h08);
      check("stuck flag", got[1], 1'b1);
      @(posedge clock_in);
      crystal_stuck_in <= 1'b0;
      // let the synchronised stuck level drop, else the set beats the clear
      cyc(2);
      wr(8'h08, 32'h5);
      rd(8'h08);
      check("flag clear", got, 32'h1);
      wr(8'h04, 32'h2);
      cyc(12);
      lowpower_exit_in <= 1'b1;
      cyc(6);
      #1 check("wake force", sysclk_select_out, 2'b00);
      @(posedge clock_in);
      lowpower_exit_in <= 1'b0;
   endtask
   // ==========================================
   // main sequence and watchdog
   initial
   begin
      {arst_n_in, write_in, read_in, usb_clock_enabled_in, pll_preselect_in} = '0;
      {adc_prescaler_msb_in, lowpower_exit_in, crystal_stuck_in} = '0;
      addr_in = 8'h00;
      wdata_in = 32'h0;
      pll_predivider_in = 4'h0;
      cyc(8);
      arst_n_in <= 1'b1;
      cyc(1);
      #1 t_reset();
      t_unmapped();
      t_decode();
      t_usb();
      t_switch();
      t_force();
      cyc(4);
      final_report();
   end
   // the whole run takes about 340 cycles; this cuts a hang short
   initial
   begin
      #100us;
      bad_count++;
      final_report();
   end
endmodule
bind clock_config clock_config_properties chk (.clock_in, .arst_n_in, .addr_in, .wdata_in,
   .write_in, .read_in, .rdata_out, .lowpower_exit_in, .crystal_stuck_in,
   .predivider_lsb_write_out, .predivider_lsb_value_out, .sysclk_select_out,
   .internal_rc_8mhz_force_on_out, .ctrl_out);
`default_nettype wire
